// ---- pkg/can_mode_pkg.sv ----
// Behaviour
// - host picks the mode with control bits 3 and 2; device adopts it
// - normal sends and receives; receive-only disables output stages, keeps receiving
// - receive-only keeps transmit blocked even with transmit data dominant
// - regulator, reset, fail-safe, sense, switch, serial on except sleep; watchdog also off under the undercurrent function
// - sleep switches the regulator off, removing application supply
// - low-line termination to regulator when active, to battery when low power
// - watchdog reset in normal or receive-only moves to stand-by
// - watchdog reset in stand-by leaves the device in stand-by
// - wake input or bus-line wake in sleep moves to stand-by
// - stand-by shows latched wake as low receive data; sleep holds it low
// - clear-bit high then low in two transfers clears the wake latch
// - stand-by to normal or receive-only clears the wake latch
// - fail-safe output high when watchdog served, low during any reset
// - stand-by watchdog runs at low current only without undercurrent function
// - stand-by fail-safe output low while undercurrent function is active
// - interrupt shows wake or sense warning; held low in sleep
// - active modes raise no wake interrupt; wake levels go to diagnosis
// - switch and cyclic sense only when selected; cyclic only in low power
// - supply-fail monitored always, readable only in stand-by
// - stand-by diagnosis latches clear on leaving stand-by
package can_mode_pkg;

  // register byte offsets, one 32-bit word each
  localparam logic [7:0] OFFSET_CONTROL = 8'h00;
  localparam logic [7:0] OFFSET_STATUS  = 8'h04;
  localparam logic [7:0] OFFSET_DIAG    = 8'h08;

  // control word field positions
  localparam int BIT_WDG_TRIGGER    = 0;
  localparam int BIT_WAKE_CLEAR     = 1;
  localparam int BIT_TRANSMIT_EN    = 2;
  localparam int BIT_NOT_STANDBY    = 3;
  localparam int BIT_CYCLIC_SENSE   = 4;
  localparam int BIT_HIGH_SIDE_ON   = 5;
  localparam int BIT_SET_FAIL_FLAG  = 6;
  localparam int BIT_UNDERCURRENT   = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // status register fields
  localparam int STATUS_MODE_LSB    = 0;
  localparam int STATUS_WAKE_LATCH  = 2;
  localparam int STATUS_CLEAR_ARMED = 3;

  // mode codes as reported in status
  localparam logic [1:0] CODE_SLEEP   = 2'h0;
  localparam logic [1:0] CODE_STANDBY = 2'h1;
  localparam logic [1:0] CODE_RX_ONLY = 2'h2;
  localparam logic [1:0] CODE_NORMAL  = 2'h3;

  // diagnosis word fields
  localparam int DIAG_VINT_FAIL = 0;
  localparam int DIAG_WAKE_ONE  = 2;
  localparam int DIAG_WAKE_TWO  = 3;

  // synchronised pin vector positions
  localparam int PIN_WAKE_ONE   = 0;
  localparam int PIN_WAKE_TWO   = 1;
  localparam int PIN_CANH_WAKE  = 2;
  localparam int PIN_CANL_WAKE  = 3;
  localparam int PIN_TX_DATA_N  = 4;
  localparam int PIN_BUS_RX_N   = 5;
  localparam int PIN_SENSE_N    = 6;
  localparam int PIN_VINT_FAIL  = 7;
  localparam int PIN_LOW_CURR   = 8;
  localparam int PIN_COUNT      = 9;

  // cyclic sense timing
  localparam int CLOCK_MHZ          = 100;
  localparam int CYCLIC_PERIOD_US   = 1000;
  localparam int CYCLIC_ON_US       = 10;
  localparam int CYCLIC_PERIOD_CYC  = CYCLIC_PERIOD_US * CLOCK_MHZ;
  localparam int CYCLIC_ON_CYC      = CYCLIC_ON_US * CLOCK_MHZ;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_RX_ONLY,
    MODE_STANDBY,
    MODE_SLEEP
  } mode_e;

  // functional enables of the device
  typedef struct packed {
    logic regulator;
    logic reset_gen;
    logic watchdog;
    logic fail_safe;
    logic sense;
    logic high_side;
    logic serial;
    logic vint_monitor;
  } power_s;

  // termination switch positions
  typedef struct packed {
    logic low_line_to_vcc;
    logic low_line_to_battery;
    logic high_line_to_ground;
  } termination_s;

endpackage

// ---- verilog/pin_sync.sv ----
// two-stage synchroniser with edge detect on the settled value
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] last;

  // stage one is read only by stage two
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      q    <= '0;
      last <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
      last <= q;
    end
  end

  assign rise = q & ~last;
  assign fall = ~q & last;

endmodule

// ---- verilog/can_node_mode_controller.sv ----
// operating mode controller; control word arrives as a wishbone write
module can_node_mode_controller #(
  parameter int CYCLIC_PERIOD = can_mode_pkg::CYCLIC_PERIOD_CYC,
  parameter int CYCLIC_ON     = can_mode_pkg::CYCLIC_ON_CYC
) (
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // wishbone classic slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // pins, asynchronous to clock
  input  wire logic                       wake_input_one,
  input  wire logic                       wake_input_two,
  input  wire logic                       canh_wake,
  input  wire logic                       canl_wake,
  input  wire logic                       tx_data_n,
  input  wire logic                       bus_rx_n,
  input  wire logic                       sense_warn_n,
  input  wire logic                       vint_fail,
  input  wire logic                       low_vcc_current,
  // from watchdog and reset logic on this clock
  input  wire logic                       watchdog_reset,
  input  wire logic                       reset_active,
  // outputs
  output logic                            bus_tx_n,
  output logic                            rx_data_out,
  output logic                            interrupt_out_n,
  output logic                            fail_safe_out_n,
  output logic                            high_side_out,
  output logic                            transmit_enable,
  output logic                            receive_enable,
  output can_mode_pkg::power_s            power,
  output can_mode_pkg::termination_s      termination
);

  logic [can_mode_pkg::PIN_COUNT-1:0] pin_raw;
  logic [can_mode_pkg::PIN_COUNT-1:0] pin_s;
  logic [can_mode_pkg::PIN_COUNT-1:0] pin_rise;
  logic [can_mode_pkg::PIN_COUNT-1:0] pin_fall;

  can_mode_pkg::mode_e mode;
  can_mode_pkg::mode_e next_mode;
  logic [7:0]          control;
  logic [7:0]          next_control;
  logic                wake_latch;
  logic                next_wake_latch;
  logic                clear_armed;
  logic                next_clear_armed;
  logic                vint_latch;
  logic                next_vint_latch;
  logic [1:0]          wake_src;
  logic [1:0]          next_wake_src;

  logic                wb_ack;
  logic                next_wb_ack;
  logic [31:0]         wb_rdata;
  logic [31:0]         next_wb_rdata;

  logic [31:0]         cyc_count;
  logic [31:0]         next_cyc_count;

  logic                ctrl_write;
  logic                wake_event;
  logic [1:0]          wake_pins;
  logic                low_power;
  logic                awake;
  logic                undercurrent;
  logic                cyc_on;
  logic                leave_standby;
  logic [7:0]          diag_word;
  logic [1:0]          mode_code;

  // every pin passes two flops before use
  assign pin_raw = {low_vcc_current, vint_fail, sense_warn_n, bus_rx_n, tx_data_n,
                    canl_wake, canh_wake, wake_input_two, wake_input_one};

  pin_sync #(
    .WIDTH (can_mode_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     (pin_raw),
    .q     (pin_s),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // wake inputs idle high and wake on a falling edge; bus wake detect pulses high
  assign wake_pins  = {pin_fall[can_mode_pkg::PIN_WAKE_TWO],
                       pin_fall[can_mode_pkg::PIN_WAKE_ONE]};
  assign wake_event = (|wake_pins)
                    | pin_rise[can_mode_pkg::PIN_CANH_WAKE]
                    | pin_rise[can_mode_pkg::PIN_CANL_WAKE];

  assign low_power = (mode == can_mode_pkg::MODE_STANDBY) ||
                     (mode == can_mode_pkg::MODE_SLEEP);
  assign awake     = (mode != can_mode_pkg::MODE_SLEEP);

  // undercurrent function only counts in stand-by with a low regulator load
  assign undercurrent = (mode == can_mode_pkg::MODE_STANDBY)
                      & control[can_mode_pkg::BIT_UNDERCURRENT]
                      & pin_s[can_mode_pkg::PIN_LOW_CURR];

  // a write takes effect at the edge where the master sees ack; serial port is off in sleep
  assign ctrl_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack & wb_sel_i[0]
                    & (wb_adr_i == can_mode_pkg::OFFSET_CONTROL) & awake;

  // mode, control word and latches
  always_comb
  begin
    next_mode        = mode;
    next_control     = control;
    next_wake_latch  = wake_latch;
    next_clear_armed = clear_armed;
    next_vint_latch  = vint_latch;
    next_wake_src    = wake_src;
    leave_standby    = 1'b0;

    if (ctrl_write)
    begin
      next_control = wb_dat_i[7:0];
      // decode of the two mode bits
      case ({wb_dat_i[can_mode_pkg::BIT_NOT_STANDBY], wb_dat_i[can_mode_pkg::BIT_TRANSMIT_EN]})
        2'h3:    next_mode = can_mode_pkg::MODE_NORMAL;
        2'h2:    next_mode = can_mode_pkg::MODE_RX_ONLY;
        2'h1:    next_mode = can_mode_pkg::MODE_STANDBY;
        default: next_mode = can_mode_pkg::MODE_SLEEP;
      endcase
      // clear sequence: a high write arms, the next low write clears
      if (wb_dat_i[can_mode_pkg::BIT_WAKE_CLEAR])
      begin
        next_clear_armed = 1'b1;
      end
      else if (clear_armed)
      begin
        next_clear_armed = 1'b0;
        next_wake_latch  = 1'b0;
      end
    end

    // a pending wake blocks sleep so the event is not swallowed
    if ((next_mode == can_mode_pkg::MODE_SLEEP) && next_wake_latch)
    begin
      next_mode = can_mode_pkg::MODE_STANDBY;
    end

    // watchdog reset overrides any command in the same cycle
    if (watchdog_reset && awake)
    begin
      next_mode = can_mode_pkg::MODE_STANDBY;
    end

    if ((mode == can_mode_pkg::MODE_STANDBY) &&
        ((next_mode == can_mode_pkg::MODE_NORMAL) ||
         (next_mode == can_mode_pkg::MODE_RX_ONLY)))
    begin
      next_wake_latch = 1'b0;
    end

    if ((mode == can_mode_pkg::MODE_STANDBY) && (next_mode != can_mode_pkg::MODE_STANDBY))
    begin
      leave_standby = 1'b1;
    end
    if (leave_standby)
    begin
      next_vint_latch = 1'b0;
      next_wake_src   = 2'h0;
    end

    // supply fail is watched in every mode; set wins over the leave clear
    if (pin_s[can_mode_pkg::PIN_VINT_FAIL] ||
        (ctrl_write && wb_dat_i[can_mode_pkg::BIT_SET_FAIL_FLAG]))
    begin
      next_vint_latch = 1'b1;
    end

    // wakes latch only in low power; active modes just report levels
    if (wake_event && low_power)
    begin
      next_wake_latch = 1'b1;
      next_wake_src   = wake_src | wake_pins;
      if (mode == can_mode_pkg::MODE_SLEEP)
      begin
        next_mode = can_mode_pkg::MODE_STANDBY;
      end
    end
  end

  // power-on lands in stand-by with everything cleared
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mode        <= can_mode_pkg::MODE_STANDBY;
      control     <= can_mode_pkg::CONTROL_RESET;
      wake_latch  <= 1'b0;
      clear_armed <= 1'b0;
      vint_latch  <= 1'b0;
      wake_src    <= 2'h0;
    end
    else
    begin
      mode        <= next_mode;
      control     <= next_control;
      wake_latch  <= next_wake_latch;
      clear_armed <= next_clear_armed;
      vint_latch  <= next_vint_latch;
      wake_src    <= next_wake_src;
    end
  end

  // free-running cyclic sense timer, only honoured in low power
  always_comb
  begin
    if (cyc_count >= (CYCLIC_PERIOD - 1))
    begin
      next_cyc_count = 32'h0;
    end
    else
    begin
      next_cyc_count = cyc_count + 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_count <= 32'h0;
    end
    else
    begin
      cyc_count <= next_cyc_count;
    end
  end

  assign cyc_on = (cyc_count < CYCLIC_ON);

  // status and diagnosis views
  always_comb
  begin
    case (mode)
      can_mode_pkg::MODE_NORMAL:  mode_code = can_mode_pkg::CODE_NORMAL;
      can_mode_pkg::MODE_RX_ONLY: mode_code = can_mode_pkg::CODE_RX_ONLY;
      can_mode_pkg::MODE_STANDBY: mode_code = can_mode_pkg::CODE_STANDBY;
      default:                    mode_code = can_mode_pkg::CODE_SLEEP;
    endcase
    diag_word = 8'h00;
    if (mode == can_mode_pkg::MODE_STANDBY)
    begin
      diag_word[can_mode_pkg::DIAG_VINT_FAIL] = vint_latch;
      diag_word[can_mode_pkg::DIAG_WAKE_ONE]  = wake_src[0];
      diag_word[can_mode_pkg::DIAG_WAKE_TWO]  = wake_src[1];
    end
    else if (!low_power)
    begin
      diag_word[can_mode_pkg::DIAG_WAKE_ONE] = pin_s[can_mode_pkg::PIN_WAKE_ONE];
      diag_word[can_mode_pkg::DIAG_WAKE_TWO] = pin_s[can_mode_pkg::PIN_WAKE_TWO];
    end
  end

  // bus slave: ack one cycle after the strobe, dropped the cycle after
  always_comb
  begin
    next_wb_ack   = wb_cyc_i & wb_stb_i & ~wb_ack;
    next_wb_rdata = 32'h0;
    if (wb_cyc_i && wb_stb_i && !wb_ack)
    begin
      case (wb_adr_i)
        can_mode_pkg::OFFSET_CONTROL: next_wb_rdata = {24'h0, control};
        can_mode_pkg::OFFSET_STATUS:
        begin
          next_wb_rdata[can_mode_pkg::STATUS_MODE_LSB +: 2] = mode_code;
          next_wb_rdata[can_mode_pkg::STATUS_WAKE_LATCH]    = wake_latch;
          next_wb_rdata[can_mode_pkg::STATUS_CLEAR_ARMED]   = clear_armed;
        end
        can_mode_pkg::OFFSET_DIAG:    next_wb_rdata = {24'h0, diag_word};
        default:                      next_wb_rdata = 32'h0;
      endcase
    end
    else if (wb_ack)
    begin
      next_wb_rdata = wb_rdata;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack   <= 1'b0;
      wb_rdata <= 32'h0;
    end
    else
    begin
      wb_ack   <= next_wb_ack;
      wb_rdata <= next_wb_rdata;
    end
  end

  assign wb_ack_o = wb_ack;
  assign wb_dat_o = wb_rdata;

  // pin and enable outputs, registered so they settle one cycle after the mode
  logic                      next_bus_tx_n;
  logic                      next_rx_data_out;
  logic                      next_interrupt_out_n;
  logic                      next_fail_safe_out_n;
  logic                      next_high_side_out;
  logic                      next_transmit_enable;
  logic                      next_receive_enable;
  can_mode_pkg::power_s      next_power;
  can_mode_pkg::termination_s next_termination;

  always_comb
  begin
    next_transmit_enable = (mode == can_mode_pkg::MODE_NORMAL);
    next_receive_enable  = !low_power;
    // transmit data reaches the bus only in normal mode
    next_bus_tx_n = next_transmit_enable ? pin_s[can_mode_pkg::PIN_TX_DATA_N] : 1'b1;

    case (mode)
      can_mode_pkg::MODE_STANDBY: next_rx_data_out = ~wake_latch;
      can_mode_pkg::MODE_SLEEP:   next_rx_data_out = 1'b0;
      default:                    next_rx_data_out = pin_s[can_mode_pkg::PIN_BUS_RX_N];
    endcase

    // wake only interrupts in stand-by; sense warning in every awake mode
    case (mode)
      can_mode_pkg::MODE_SLEEP:   next_interrupt_out_n = 1'b0;
      can_mode_pkg::MODE_STANDBY:
        next_interrupt_out_n = ~(wake_latch | ~pin_s[can_mode_pkg::PIN_SENSE_N]);
      default: next_interrupt_out_n = pin_s[can_mode_pkg::PIN_SENSE_N];
    endcase

    // low in reset, in sleep, and under the undercurrent function
    next_fail_safe_out_n = awake & ~reset_active & ~undercurrent;

    next_high_side_out = (control[can_mode_pkg::BIT_HIGH_SIDE_ON] & awake)
                       | (control[can_mode_pkg::BIT_CYCLIC_SENSE] & low_power & cyc_on);

    next_power.regulator    = awake;
    next_power.reset_gen    = awake;
    next_power.watchdog     = awake & ~undercurrent;
    next_power.fail_safe    = awake;
    next_power.sense        = awake;
    next_power.high_side    = awake;
    next_power.serial       = awake;
    next_power.vint_monitor = 1'b1;

    next_termination.low_line_to_vcc     = !low_power;
    next_termination.low_line_to_battery = low_power;
    next_termination.high_line_to_ground = 1'b1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_tx_n        <= 1'b1;
      rx_data_out     <= 1'b1;
      interrupt_out_n <= 1'b1;
      fail_safe_out_n <= 1'b0;
      high_side_out   <= 1'b0;
      transmit_enable <= 1'b0;
      receive_enable  <= 1'b0;
      power           <= '0;
      termination     <= '0;
    end
    else
    begin
      bus_tx_n        <= next_bus_tx_n;
      rx_data_out     <= next_rx_data_out;
      interrupt_out_n <= next_interrupt_out_n;
      fail_safe_out_n <= next_fail_safe_out_n;
      high_side_out   <= next_high_side_out;
      transmit_enable <= next_transmit_enable;
      receive_enable  <= next_receive_enable;
      power           <= next_power;
      termination     <= next_termination;
    end
  end

endmodule

// ---- verification/can_mode_asserts.sv ----
module can_mode_asserts (
  input wire logic                       clock,
  input wire logic                       rstn,
  input wire logic                       watchdog_reset,
  input wire logic                       reset_active,
  input wire logic                       wake_input_one,
  input wire logic                       bus_tx_n,
  input wire logic                       rx_data_out,
  input wire logic                       interrupt_out_n,
  input wire logic                       fail_safe_out_n,
  input wire logic                       transmit_enable,
  input wire logic                       receive_enable,
  input wire can_mode_pkg::power_s       power,
  input wire can_mode_pkg::termination_s termination
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] up;
  logic [1:0] next_up;
  // two edges of grace: outputs take stand-by values one edge after release
  always_comb next_up = {up[0], 1'b1};
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      up <= 2'h0;
    else
      up <= next_up;
  default clocking @(posedge clock); endclocking
  default disable iff (!up[1]);
  sequence s_asleep;
    !power.serial;
  endsequence
  sequence s_wake_in_sleep;
    $fell(wake_input_one) && !power.serial;
  endsequence
  chk_tx_blocked: assert property (!transmit_enable |-> bus_tx_n)
    else $error("bus driven while transmit off");
  chk_tx_needs_rx: assert property (transmit_enable |-> receive_enable)
    else $error("transmit without receive");
  chk_sleep_off: assert property (s_asleep |-> !power.regulator && !power.high_side
    && !power.watchdog && power.vint_monitor) else $error("sleep enables wrong");
  chk_term_route: assert property (termination.low_line_to_vcc == receive_enable
    && termination.low_line_to_battery == !receive_enable) else $error("termination wrong");
  chk_sleep_flags: assert property (s_asleep |-> !rx_data_out && !interrupt_out_n)
    else $error("sleep flags not low");
  chk_wdg_fallback: assert property (watchdog_reset && receive_enable
    |-> ##[1:3] !receive_enable && power.serial) else $error("no stand-by after watchdog");
  chk_wdg_stays: assert property (watchdog_reset && power.serial && !receive_enable
    |=> ##1 power.serial && !receive_enable) else $error("left stand-by on watchdog");
  chk_fail_reset: assert property (reset_active |=> !fail_safe_out_n)
    else $error("fail-safe high in reset");
  chk_under_fail: assert property (power.serial && !power.watchdog |-> !fail_safe_out_n)
    else $error("fail-safe high with undercurrent");
  chk_wake_sleep: assert property (s_wake_in_sleep |-> ##[1:10] power.serial)
    else $error("no wake from sleep");
endmodule

bind can_node_mode_controller can_mode_asserts can_mode_asserts_i (
  .clock(clock), .rstn(rstn), .watchdog_reset(watchdog_reset),
  .reset_active(reset_active), .wake_input_one(wake_input_one), .bus_tx_n(bus_tx_n),
  .rx_data_out(rx_data_out), .interrupt_out_n(interrupt_out_n),
  .fail_safe_out_n(fail_safe_out_n), .transmit_enable(transmit_enable),
  .receive_enable(receive_enable), .power(power), .termination(termination)
);

// ---- verification/can_bus_partner.sv ----
module can_bus_partner (
  input  wire logic link_clock,
  input  wire logic frame_on,
  input  wire logic remote_n,
  input  wire logic bus_tx_n,
  output logic      tx_data_n,
  output logic      bus_rx_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pat;
  // protocol controller toggles its data each link bit
  initial pat = 1'b1;
  always @(posedge link_clock)
    pat <= ~pat;
  // pull-up makes the line recessive between frames
  assign tx_data_n = frame_on ? pat : 1'b1;
  // wired bus: any dominant node pulls the level low
  assign bus_rx_n = bus_tx_n & remote_n;
endmodule

// ---- verification/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SETTLE = 8;
  logic clock, rstn, cyc, stb, we, ack, lclk, frame_on, remote_n;
  logic sense_n, vint, lowcur, wdg, rst_act, bus_tx_n, rx_out, int_n, fso_n, hs, te, re;
  logic tx_n, brx_n;
  logic [3:0]  sel, w;
  logic [7:0]  adr;
  logic [15:0] lfsr;
  logic [31:0] dat, rd_o, rdat;
  can_mode_pkg::power_s       power;
  can_mode_pkg::termination_s term;
  int err_total, total_checks, n;
  can_node_mode_controller #(.CYCLIC_PERIOD(20), .CYCLIC_ON(4)) can_node_mode_controller_i (
    .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd_o), .wb_ack_o(ack),
    .wake_input_one(w[0]), .wake_input_two(w[1]), .canh_wake(w[2]), .canl_wake(w[3]),
    .tx_data_n(tx_n), .bus_rx_n(brx_n), .sense_warn_n(sense_n), .vint_fail(vint),
    .low_vcc_current(lowcur), .watchdog_reset(wdg), .reset_active(rst_act),
    .bus_tx_n(bus_tx_n), .rx_data_out(rx_out), .interrupt_out_n(int_n),
    .fail_safe_out_n(fso_n), .high_side_out(hs), .transmit_enable(te),
    .receive_enable(re), .power(power), .termination(term));
  can_bus_partner can_bus_partner_i (.link_clock(lclk & frame_on), .frame_on(frame_on),
    .remote_n(remote_n), .bus_tx_n(bus_tx_n), .tx_data_n(tx_n), .bus_rx_n(brx_n));
  // clocks: link edges never meet the system rising edges
  always #5 clock = ~clock;
  always #40 lclk = ~lclk;
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] mode_code(input logic [1:0] s);
    case (s)
      2'h3: return {30'h0, can_mode_pkg::CODE_NORMAL};
      2'h2: return {30'h0, can_mode_pkg::CODE_RX_ONLY};
      2'h1: return {30'h0, can_mode_pkg::CODE_STANDBY};
      default: return {30'h0, can_mode_pkg::CODE_SLEEP};
    endcase
  endfunction
  // random far-node traffic on the bus
  always @(posedge clock)
  begin
    lfsr <= lfsr_next(lfsr);
    remote_n <= lfsr[0];
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold until ack seen, release at the edge that samples it
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dat <= d;
    sel <= 4'h1;
    k = 0;
    // ack is seen here as sampled at the edge; data and release belong to that edge
    do
    begin
      @(posedge clock);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1)
    begin
      err_total++;
      give_verdict();
    end
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    repeat (SETTLE) @(posedge clock);
  endtask
  // counts cycles with high-side on, or with the bus driven dominant
  task automatic count(input logic side, output int c);
    c = 0;
    repeat (24)
    begin
      @(posedge clock);
      c += side ? int'(hs === 1'b1) : int'(bus_tx_n === 1'b0);
    end
  endtask
  initial
  begin
    {clock, lclk, rstn, cyc, stb, we, vint, lowcur, wdg, rst_act, frame_on} = '0;
    {sense_n, remote_n} = 2'h3;
    {sel, adr, dat} = '0;
    w = 4'h3;
    lfsr = 16'hae65;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    wb(0, can_mode_pkg::OFFSET_STATUS, 0);
    chk(rdat, 32'h1);
    wb(0, can_mode_pkg::OFFSET_CONTROL, 0);
    chk(rdat, 32'h0);
    frame_on <= 1'b1;
    for (int s = 3; s > 0; s--)
    begin
      wb(1, can_mode_pkg::OFFSET_CONTROL, 32'(s << 2));
      wb(0, can_mode_pkg::OFFSET_STATUS, 0);
      chk(rdat, mode_code(2'(s)));
      chk({te, re, term}, {s == 3, s > 1, s > 1, s < 2, 1'b1});
      count(0, n);
      chk(n > 0, s == 3);
    end
    frame_on <= 1'b0;
    vint <= 1'b1;
    // the pin needs its two sync flops and the latch edge before the read samples it
    repeat (SETTLE) @(posedge clock);
    wb(0, can_mode_pkg::OFFSET_DIAG, 0);
    chk(rdat[0], 1'b1);
    vint <= 1'b0;
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'hc);
    wb(0, can_mode_pkg::OFFSET_DIAG, 0);
    chk(rdat, 32'hc);
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'h4);
    wb(0, can_mode_pkg::OFFSET_DIAG, 0);
    chk(rdat, 32'h0);
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'hc);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clock);
      wdg <= 1'b1;
      @(posedge clock);
      wdg <= 1'b0;
      wb(0, can_mode_pkg::OFFSET_STATUS, 0);
      chk(rdat, 32'h1);
    end
    rst_act <= 1'b1;
    repeat (3) @(posedge clock);
    chk(fso_n, 1'b0);
    rst_act <= 1'b0;
    lowcur <= 1'b1;
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'h84);
    chk({fso_n, power.watchdog, power.serial}, 3'h1);
    lowcur <= 1'b0;
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'h2c);
    chk(hs, 1'b1);
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'h1c);
    count(1, n);
    chk(n, 0);
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'h14);
    count(1, n);
    chk(n > 0, 1'b1);
    wb(0, 8'h10, 0);
    chk(rdat, 32'h0);
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'h0);
    chk({power.regulator, rx_out, int_n}, 3'h0);
    w <= w ^ (4'h1 << lfsr[1:0]);
    repeat (SETTLE) @(posedge clock);
    w <= 4'h3;
    wb(0, can_mode_pkg::OFFSET_STATUS, 0);
    chk({rdat, rx_out}, {32'h5, 1'b0});
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'h2);
    wb(0, can_mode_pkg::OFFSET_STATUS, 0);
    chk(rdat, 32'hd);
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'h0);
    chk(power.serial, 1'b0);
    w <= 4'h2;
    repeat (SETTLE) @(posedge clock);
    wb(1, can_mode_pkg::OFFSET_CONTROL, 32'hc);
    wb(0, can_mode_pkg::OFFSET_STATUS, 0);
    chk(rdat, 32'h3);
    give_verdict();
  end
endmodule
